// file: shared/rbs_pkg.sv
// Summary of operation
// - Pin reset sampled on running clock
// - Held while pin high, release two machine cycles after it falls
// - No flag records a pin reset
// - Power-down pin reset restarts clock first
// - Watchdog timeout resets whole system directly
// - Watchdog reset held two machine cycles
// - Watchdog flag bit 3, cleared by power-on/write
// - Soft reset trigger bit 7, hardware clears
// - Soft reset flag bit 0, survives warm resets
// - Boot select write picks next region
// - Boot select read shows previous region
// - Boot select loads inverted config bit 7
// - Fetch region taken from boot select
// - Config boot bit unprogrammed is one
// - Reset leaves data RAM untouched
// - PC forced 0000H, SP set 07H
// - Interrupts and timers disabled on reset
// - Port latches loaded with FFH
package rbs_pkg;
   localparam logic [7:0]  ADDR_CHIP_CTRL  = 8'h9F;
   localparam logic [7:0]  ADDR_WDOG_CTRL  = 8'hAA;
   localparam logic [7:0]  ADDR_RST_SRC    = 8'h96;
   localparam logic [7:0]  ADDR_TA_KEY     = 8'hC7;
   localparam logic [7:0]  ADDR_BOOT_CFG   = 8'hF0;
   localparam logic [7:0]  KEY_FIRST       = 8'hAA;
   localparam logic [7:0]  KEY_SECOND      = 8'h55;
   localparam int          BIT_SOFT_TRIG   = 7;
   localparam int          BIT_BOOT_SEL    = 1;
   localparam int          BIT_WDOG_FLAG   = 3;
   localparam int          BIT_SOFT_FLAG   = 0;
   localparam int          BIT_CFG_BOOT    = 7;
   localparam logic [7:0]  CFG_RESET       = 8'hFF;
   localparam logic [15:0] PC_RESET        = 16'h0000;
   localparam logic [7:0]  SP_RESET        = 8'h07;
   localparam logic [7:0]  PORT_RESET      = 8'hFF;
   localparam int          CLK_PER_MCYC    = 12;
   localparam int          HOLD_MCYC       = 2;
   localparam int          HOLD_CYC        = CLK_PER_MCYC * HOLD_MCYC;
   localparam int          STABLE_CYC      = 64;
   typedef enum logic [1:0] {ST_RUN, ST_WAKE, ST_HOLD} rbs_state_t;
endpackage

// file: rtl/rbs_reset_boot.sv
`timescale 1ns/1ps
module rbs_reset_boot #(
   parameter int STABLE_CYCLES = rbs_pkg::STABLE_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        rstPin,
   input  wire logic        wdogTimeout,
   input  wire logic        powerDown,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [7:0]  regRdata,
   output logic             clkRestart,
   output logic             cpuRst,
   output logic             bootLoader,
   output logic      [15:0] pcInit,
   output logic      [7:0]  spInit,
   output logic      [7:0]  portInit,
   output logic             intDisable,
   output logic             timerDisable
);
   // Two-stage release of the power-on reset
   logic rstSync1_ff, rstSync2_ff;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync1_ff <= 1'b0;
         rstSync2_ff <= 1'b0;
      end else begin
         rstSync1_ff <= 1'b1;
         rstSync2_ff <= rstSync1_ff;
      end
   end
   wire porN = rstSync2_ff;

   rbs_pkg::rbs_state_t state_ff, nxt_state;
   logic [7:0]  holdCnt_ff, nxt_holdCnt;
   logic [15:0] wakeCnt_ff, nxt_wakeCnt;
   logic        keyStage_ff, keyOpen_ff;
   logic        softTrig_ff, bootSel_ff, bootPrev_ff, wdFlag_ff, swFlag_ff;
   logic        swPending_ff, wdPending_ff;
   logic [7:0]  cfgByte_ff;
   logic        cfgLoaded_ff;

   // Address decode
   wire wrChip = regWr && regAddr == rbs_pkg::ADDR_CHIP_CTRL;
   wire wrWdog = regWr && regAddr == rbs_pkg::ADDR_WDOG_CTRL;
   wire wrRsrc = regWr && regAddr == rbs_pkg::ADDR_RST_SRC;
   wire wrKey  = regWr && regAddr == rbs_pkg::ADDR_TA_KEY;
   wire wrCfg  = regWr && regAddr == rbs_pkg::ADDR_BOOT_CFG;
   wire wrChipOk = wrChip && keyOpen_ff;
   wire wrWdogOk = wrWdog && keyOpen_ff;
   wire swReq = wrChipOk && regWdata[rbs_pkg::BIT_SOFT_TRIG];
   // Pin and watchdog taken on clock
   wire inHold = state_ff == rbs_pkg::ST_HOLD;
   wire anyReq = rstPin || wdogTimeout || swReq;

   // Reset sequencer
   always_comb begin
      nxt_state   = state_ff;
      nxt_holdCnt = holdCnt_ff;
      nxt_wakeCnt = wakeCnt_ff;
      case (state_ff)
         rbs_pkg::ST_RUN: begin
            if (rstPin && powerDown) begin
               nxt_state   = rbs_pkg::ST_WAKE;
               nxt_wakeCnt = 16'h0000;
            end else if (anyReq) begin
               nxt_state   = rbs_pkg::ST_HOLD;
               nxt_holdCnt = 8'h00;
            end
         end
         rbs_pkg::ST_WAKE: begin
            nxt_wakeCnt = wakeCnt_ff + 16'h0001;
            if (32'(wakeCnt_ff) >= STABLE_CYCLES - 1) begin
               nxt_state   = rbs_pkg::ST_HOLD;
               nxt_holdCnt = 8'h00;
            end
         end
         rbs_pkg::ST_HOLD: begin
            if (rstPin) begin
               nxt_holdCnt = 8'h00;
            end else if (32'(holdCnt_ff) >= rbs_pkg::HOLD_CYC - 1) begin
               nxt_state = rbs_pkg::ST_RUN;
            end else begin
               nxt_holdCnt = holdCnt_ff + 8'h01;
            end
         end
         default: nxt_state = rbs_pkg::ST_RUN;
      endcase
   end

   wire holdEnd = inHold && !rstPin && 32'(holdCnt_ff) >= rbs_pkg::HOLD_CYC - 1;
   wire keyWrFirst = wrKey && regWdata == rbs_pkg::KEY_FIRST;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff    <= rbs_pkg::ST_HOLD;
         holdCnt_ff  <= 8'h00;
         wakeCnt_ff  <= 16'h0000;
      end else begin
         state_ff    <= nxt_state;
         holdCnt_ff  <= nxt_holdCnt;
         wakeCnt_ff  <= nxt_wakeCnt;
      end
   end

   // Key unlock: open for exactly the next write
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         keyStage_ff <= 1'b0;
         keyOpen_ff  <= 1'b0;
      end else if (regWr) begin
         keyStage_ff <= keyWrFirst;
         keyOpen_ff  <= keyStage_ff && wrKey && regWdata == rbs_pkg::KEY_SECOND;
      end
   end

   // Source tracking and flags; power-on clears all, warm resets clear the trigger and pending bits but keep the flags
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         softTrig_ff  <= 1'b0;
         swPending_ff <= 1'b0;
         wdPending_ff <= 1'b0;
         wdFlag_ff    <= 1'b0;
         swFlag_ff    <= 1'b0;
      end else if (!porN) begin
         softTrig_ff  <= 1'b0;
         swPending_ff <= 1'b0;
         wdPending_ff <= 1'b0;
         wdFlag_ff    <= 1'b0;
         swFlag_ff    <= 1'b0;
      end else begin
         softTrig_ff  <= holdEnd ? 1'b0 : (softTrig_ff | swReq);
         swPending_ff <= holdEnd ? 1'b0 : (swPending_ff | swReq);
         wdPending_ff <= holdEnd ? 1'b0 : (wdPending_ff | wdogTimeout);
         if (wdogTimeout)
            wdFlag_ff <= 1'b1;
         else if (wrWdogOk && !regWdata[rbs_pkg::BIT_WDOG_FLAG])
            wdFlag_ff <= 1'b0;
         if (holdEnd && swPending_ff)
            swFlag_ff <= 1'b1;
         else if (wrRsrc && !regWdata[rbs_pkg::BIT_SOFT_FLAG])
            swFlag_ff <= 1'b0;
      end
   end

   // Boot select: write holds next choice, read shows previous
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfgByte_ff   <= rbs_pkg::CFG_RESET;
         cfgLoaded_ff <= 1'b0;
         bootSel_ff   <= 1'b0;
         bootPrev_ff  <= 1'b0;
      end else begin
         if (wrCfg)
            cfgByte_ff <= regWdata;
         // Inverted config bit unless soft reset
         if (!cfgLoaded_ff || (holdEnd && !swPending_ff)) begin
            bootSel_ff   <= ~cfgByte_ff[rbs_pkg::BIT_CFG_BOOT];
            cfgLoaded_ff <= 1'b1;
         end else if (wrChipOk) begin
            bootSel_ff <= regWdata[rbs_pkg::BIT_BOOT_SEL];
         end
         // Region latched at release: select after soft reset, else inverted config bit
         if (holdEnd) begin
            bootPrev_ff <= (!swPending_ff) ? ~cfgByte_ff[rbs_pkg::BIT_CFG_BOOT] : bootSel_ff;
         end
      end
   end

   // Only control state is reset, RAM untouched
   // Wake wait is not reset yet: the clock must settle first
   assign cpuRst       = inHold;
   assign clkRestart   = state_ff == rbs_pkg::ST_WAKE;
   assign bootLoader   = bootPrev_ff;
   assign pcInit       = rbs_pkg::PC_RESET;
   assign spInit       = rbs_pkg::SP_RESET;
   assign portInit     = rbs_pkg::PORT_RESET;
   assign intDisable   = cpuRst;
   assign timerDisable = cpuRst;

   // Read mux; no pin-reset flag exists anywhere
   logic [7:0] rdMux;
   always_comb begin
      rdMux = 8'h00;
      case (regAddr)
         rbs_pkg::ADDR_CHIP_CTRL: rdMux[rbs_pkg::BIT_BOOT_SEL] = bootPrev_ff;
         rbs_pkg::ADDR_WDOG_CTRL: rdMux[rbs_pkg::BIT_WDOG_FLAG] = wdFlag_ff;
         rbs_pkg::ADDR_RST_SRC:   rdMux[rbs_pkg::BIT_SOFT_FLAG] = swFlag_ff;
         rbs_pkg::ADDR_BOOT_CFG:  rdMux = cfgByte_ff;
         default:                 rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         regRdata <= 8'h00;
      else
         regRdata <= regRd ? rdMux : 8'h00;
   end

   // Checks
   property p_pin_hold;
      @(posedge sys_clk) disable iff (!nrst)
      rstPin && !powerDown |=> cpuRst; // timing
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin reset not applied");
   property p_release;
      @(posedge sys_clk) disable iff (!nrst)
      $fell(rstPin) && inHold |-> ##[1:30] !cpuRst;
   endproperty
   a_release: assert property (p_release) else $error("late release");
   property p_wd_flag;
      @(posedge sys_clk) disable iff (!nrst || !porN)
      wdogTimeout |=> wdFlag_ff;
   endproperty
   a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag missing");
   property p_wd_hold;
      @(posedge sys_clk) disable iff (!nrst)
      wdogTimeout && state_ff == rbs_pkg::ST_RUN && !rstPin |=> cpuRst [*8];
   endproperty
   a_wd_hold: assert property (p_wd_hold) else $error("watchdog hold short");
   property p_trig_clear;
      @(posedge sys_clk) disable iff (!nrst)
      holdEnd |=> !softTrig_ff;
   endproperty
   a_trig_clear: assert property (p_trig_clear) else $error("trigger stuck");
   property p_sw_flag;
      @(posedge sys_clk) disable iff (!nrst || !porN)
      holdEnd && swPending_ff |=> swFlag_ff;
   endproperty
   a_sw_flag: assert property (p_sw_flag) else $error("soft flag missing");
   property p_boot;
      @(posedge sys_clk) disable iff (!nrst)
      holdEnd && swPending_ff |=> bootLoader == $past(bootSel_ff);
   endproperty
   a_boot: assert property (p_boot) else $error("wrong boot region");
   property p_wake;
      @(posedge sys_clk) disable iff (!nrst)
      rstPin && powerDown && state_ff == rbs_pkg::ST_RUN |=> clkRestart;
   endproperty
   a_wake: assert property (p_wake) else $error("clock not restarted");

   // Step sequences of the multi-cycle behaviours
   sequence s_wake_req;
      state_ff == rbs_pkg::ST_RUN && rstPin && powerDown;
   endsequence
   sequence s_soft_req;
      state_ff == rbs_pkg::ST_RUN && swReq && !rstPin && !powerDown;
   endsequence

   // Clock restart lasts at least four cycles before any reset
   property p_wake_len;
      @(posedge sys_clk) disable iff (!nrst)
      s_wake_req |=> clkRestart [*4];
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake wait short");

   // No reset while the clock is still settling
   property p_wake_no_rst;
      @(posedge sys_clk) disable iff (!nrst)
      state_ff == rbs_pkg::ST_WAKE |-> !cpuRst;
   endproperty
   a_wake_no_rst: assert property (p_wake_no_rst) else $error("reset during wake");

   // Software trigger enters reset on the next edge
   property p_soft_enter;
      @(posedge sys_clk) disable iff (!nrst)
      s_soft_req |=> cpuRst ##1 softTrig_ff;
   endproperty
   a_soft_enter: assert property (p_soft_enter) else $error("soft reset missed");

   // Unkeyed chip control write must not reset
   property p_key_refuse;
      @(posedge sys_clk) disable iff (!nrst)
      state_ff == rbs_pkg::ST_RUN && wrChip && !keyOpen_ff && !rstPin && !wdogTimeout
         |=> !cpuRst;
   endproperty
   a_key_refuse: assert property (p_key_refuse) else $error("unkeyed write acted");

   // Pin high keeps the hold state
   property p_pin_stay;
      @(posedge sys_clk) disable iff (!nrst)
      inHold && rstPin |=> inHold;
   endproperty
   a_pin_stay: assert property (p_pin_stay) else $error("left reset with pin high");

   // Watchdog flag only moves on its event or a keyed clear
   property p_wd_keep;
      @(posedge sys_clk) disable iff (!nrst || !porN)
      !wdogTimeout && !(wrWdogOk && !regWdata[rbs_pkg::BIT_WDOG_FLAG]) |=> $stable(wdFlag_ff);
   endproperty
   a_wd_keep: assert property (p_wd_keep) else $error("watchdog flag moved");

   // Soft flag survives warm resets
   property p_sw_keep;
      @(posedge sys_clk) disable iff (!nrst || !porN)
      !(holdEnd && swPending_ff) && !(wrRsrc && !regWdata[rbs_pkg::BIT_SOFT_FLAG])
         |=> $stable(swFlag_ff);
   endproperty
   a_sw_keep: assert property (p_sw_keep) else $error("soft flag moved");

   // Warm non-software reset reloads the inverted config bit
   property p_boot_load;
      @(posedge sys_clk) disable iff (!nrst)
      holdEnd && !swPending_ff |=> bootSel_ff == ~$past(cfgByte_ff[rbs_pkg::BIT_CFG_BOOT]);
   endproperty
   a_boot_load: assert property (p_boot_load) else $error("boot select not loaded");

   // Software reset leaves the select alone
   property p_boot_keep;
      @(posedge sys_clk) disable iff (!nrst)
      holdEnd && swPending_ff && cfgLoaded_ff && !wrChipOk |=> $stable(bootSel_ff);
   endproperty
   a_boot_keep: assert property (p_boot_keep) else $error("boot select changed");

   // Reset source register never shows a pin bit
   property p_no_pin_flag;
      @(posedge sys_clk) disable iff (!nrst)
      regRd && regAddr == rbs_pkg::ADDR_RST_SRC |=> regRdata[7:1] == 7'h00;
   endproperty
   a_no_pin_flag: assert property (p_no_pin_flag) else $error("extra source bit");

   // Read data stands only after a read strobe
   property p_rd_idle;
      @(posedge sys_clk) disable iff (!nrst)
      !regRd |=> regRdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stale read data");

   // Architectural values presented during reset
   property p_arch_vals;
      @(posedge sys_clk) disable iff (!nrst)
      cpuRst |-> pcInit == rbs_pkg::PC_RESET && spInit == rbs_pkg::SP_RESET;
   endproperty
   a_arch_vals: assert property (p_arch_vals) else $error("bad pc or sp");

   // Ports high, interrupts and timers off in reset
   property p_periph_off;
      @(posedge sys_clk) disable iff (!nrst)
      cpuRst |-> portInit == rbs_pkg::PORT_RESET && intDisable && timerDisable;
   endproperty
   a_periph_off: assert property (p_periph_off) else $error("peripherals not reset");
endmodule

// file: verif/rbs_cpu_model.sv
`timescale 1ns/1ps
module rbs_cpu_model (
   input  wire logic       sys_clk,
   input  wire logic       cpuRst,
   input  wire logic       pinGo,
   input  wire logic [7:0] pinCycles,
   output logic            rstPin,
   output logic      [7:0] releaseCnt
);
   logic [7:0] pinCntFf;
   logic       rstDlyFf;

   initial begin
      rstPin = 1'b0;
      pinCntFf = 8'h00;
      releaseCnt = 8'h00;
      rstDlyFf = 1'b0;
   end

   // Pin minimum width
   // Short requests are stretched, a shorter pulse is not a valid reset
   always @(posedge sys_clk) begin
      if (pinGo) begin
         pinCntFf <= (pinCycles < 8'(rbs_pkg::HOLD_CYC)) ? 8'(rbs_pkg::HOLD_CYC) : pinCycles;
         rstPin <= 1'b1;
      end else if (pinCntFf > 8'h01) begin
         pinCntFf <= pinCntFf - 8'h01;
      end else begin
         pinCntFf <= 8'h00;
         rstPin <= 1'b0;
      end
   end

   // Core restarts fetching on each release
   always @(posedge sys_clk) begin
      rstDlyFf <= cpuRst;
      if (rstDlyFf && !cpuRst) begin
         releaseCnt <= releaseCnt + 8'h01;
      end
   end
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin nErrors++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
   logic        sysClk = 1'b0;
   logic        nrst = 1'b0;
   logic        wdogTimeout = 1'b0;
   logic        powerDown = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWdata = 8'h00;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic        pinGo = 1'b0;
   logic [7:0]  regRdata, spInit, portInit, rd;
   logic [15:0] pcInit;
   logic [7:0]  relCnt;
   logic        rstPin, clkRestart, cpuRst, bootLoader, intDisable, timerDisable;
   int          nErrors = 0;
   int          checkCount = 0;
   int          n;

   always #12.5 sysClk = ~sysClk;

   rbs_reset_boot #(.STABLE_CYCLES(4)) u_dut (.sys_clk(sysClk), .nrst(nrst), .rstPin(rstPin),
      .wdogTimeout(wdogTimeout), .powerDown(powerDown), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .clkRestart(clkRestart), .cpuRst(cpuRst), .bootLoader(bootLoader), .pcInit(pcInit),
      .spInit(spInit), .portInit(portInit), .intDisable(intDisable),
      .timerDisable(timerDisable));

   rbs_cpu_model u_cpu (.sys_clk(sysClk), .cpuRst(cpuRst), .pinGo(pinGo),
      .pinCycles(8'h1E), .rstPin(rstPin), .releaseCnt(relCnt));

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // One-cycle strobes launched just after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sysClk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sysClk);
      regWr <= 1'b0;
   endtask

   task automatic rdReg(input logic [7:0] a);
      @(posedge sysClk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sysClk);
      regRd <= 1'b0;
      #1 rd = regRdata;
   endtask

   task automatic unlock(input logic [7:0] a, input logic [7:0] d);
      wr(rbs_pkg::ADDR_TA_KEY, rbs_pkg::KEY_FIRST);
      wr(rbs_pkg::ADDR_TA_KEY, rbs_pkg::KEY_SECOND);
      wr(a, d);
   endtask

   // Bounded wait, n ends as the cycles spent
   task automatic waitRst(input logic v);
      n = 0;
      while (cpuRst !== v) begin
         @(posedge sysClk);
         #1 n++;
         if (n > 400) begin
            nErrors++;
            complete_run();
         end
      end
   endtask

   task automatic pinPulse();
      @(posedge sysClk);
      pinGo <= 1'b1;
      @(posedge sysClk);
      pinGo <= 1'b0;
   endtask

   initial begin
      repeat (10) @(posedge sysClk);
      `CHK(cpuRst, 1'b1)
      `CHK(pcInit, rbs_pkg::PC_RESET)
      `CHK(spInit, rbs_pkg::SP_RESET)
      `CHK(portInit, rbs_pkg::PORT_RESET)
      `CHK({intDisable, timerDisable}, 2'b11)
      nrst <= 1'b1;
      waitRst(1'b0);
      rdReg(rbs_pkg::ADDR_BOOT_CFG);
      `CHK(rd, rbs_pkg::CFG_RESET)
      `CHK(bootLoader, 1'b0)
      rdReg(rbs_pkg::ADDR_CHIP_CTRL);
      `CHK(rd[1], 1'b0)
      // Config bit 7 low asks for the loader region
      wr(rbs_pkg::ADDR_BOOT_CFG, 8'h7F);
      pinPulse();
      waitRst(1'b1);
      while (rstPin === 1'b1) @(posedge sysClk);
      waitRst(1'b0);
      `CHK(n <= rbs_pkg::HOLD_CYC + 3, 1'b1)
      rdReg(rbs_pkg::ADDR_RST_SRC);
      `CHK(rd, 8'h00)
      `CHK(bootLoader, 1'b1)
      rdReg(rbs_pkg::ADDR_CHIP_CTRL);
      `CHK(rd[1], 1'b1)
      // A write without the key must be ignored
      wr(rbs_pkg::ADDR_CHIP_CTRL, 8'h80);
      repeat (30) @(posedge sysClk);
      `CHK(cpuRst, 1'b0)
      unlock(rbs_pkg::ADDR_CHIP_CTRL, 8'h80);
      waitRst(1'b1);
      waitRst(1'b0);
      // Rising wait sees reset one cycle after it starts
      `CHK(n + 1, rbs_pkg::HOLD_CYC)
      rdReg(rbs_pkg::ADDR_RST_SRC);
      `CHK(rd[0], 1'b1)
      rdReg(rbs_pkg::ADDR_CHIP_CTRL);
      `CHK(rd[7], 1'b0)
      `CHK(bootLoader, 1'b0)
      @(posedge sysClk);
      wdogTimeout <= 1'b1;
      @(posedge sysClk);
      wdogTimeout <= 1'b0;
      waitRst(1'b1);
      waitRst(1'b0);
      `CHK(n + 1, rbs_pkg::HOLD_CYC)
      rdReg(rbs_pkg::ADDR_WDOG_CTRL);
      `CHK(rd[3], 1'b1)
      rdReg(rbs_pkg::ADDR_RST_SRC);
      `CHK(rd[0], 1'b1)
      `CHK(bootLoader, 1'b1)
      // Pin reset in power-down restarts the clock before reset
      powerDown <= 1'b1;
      pinPulse();
      for (n = 0; n < 10 && clkRestart !== 1'b1; n++) begin
         @(posedge sysClk);
         #1;
      end
      `CHK(clkRestart, 1'b1)
      `CHK(cpuRst, 1'b0)
      waitRst(1'b1);
      powerDown <= 1'b0;
      waitRst(1'b0);
      rdReg(rbs_pkg::ADDR_WDOG_CTRL);
      `CHK(rd[3], 1'b1)
      unlock(rbs_pkg::ADDR_WDOG_CTRL, 8'h00);
      rdReg(rbs_pkg::ADDR_WDOG_CTRL);
      `CHK(rd[3], 1'b0)
      wr(rbs_pkg::ADDR_RST_SRC, 8'h00);
      rdReg(rbs_pkg::ADDR_RST_SRC);
      `CHK(rd[0], 1'b0)
      // Power-on, pin, soft, watchdog and wake releases
      `CHK(relCnt, 8'h05)
      complete_run();
   end
endmodule
